// >>> design/dbg_cfg_pkg.sv
/*
  shared constants and carriers of the debug configuration and status byte block.
  assumes one system clock and the debug command transport decoding host bytes
  into one-cycle command strobes on that same clock.
*/
package dbg_cfg_pkg;
   // byte width of both registers
   localparam int BYTE_W = 8;

   // configuration field positions
   localparam int CFG_RETAIN_BIT = 5;
   localparam int CFG_TIMERS_OFF_BIT = 3;
   localparam int CFG_DMA_PAUSE_BIT = 2;
   localparam int CFG_SUSPEND_BIT = 1;
   // writable bits; reserved 7:6, 4 and 0 stay zero
   localparam logic [7:0] CFG_WRITE_MASK = 8'h2E;
   // configuration reset: retain, dma pause and suspend set
   localparam logic [7:0] CFG_RESET = 8'h26;

   // status field positions
   localparam int STS_ERASE_BUSY_BIT = 7;
   localparam int STS_OSC_STABLE_BIT = 1;
   // status bits fed by other logic of the chip (6:2 and 0)
   localparam logic [7:0] STS_OTHER_MASK = 8'h7D;
   localparam logic [7:0] STS_RESET = 8'h00;

   // commands that reach this block
   typedef enum logic [1:0] {
      OP_WR_CONFIG = 2'b00,
      OP_RD_CONFIG = 2'b01,
      OP_RD_STATUS = 2'b10,
      OP_CHIP_ERASE = 2'b11
   } cmd_op_e;

   // one decoded command strobe with its data byte
   typedef struct packed {
      logic valid;
      cmd_op_e op;
      logic [7:0] data;
   } cmd_s;

   // one answer byte
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rsp_s;
endpackage : dbg_cfg_pkg

// >>> design/debug_config_status.sv
/*
  debug configuration byte and debug status byte with their effects on the chip:
  regulator retention, debug logic reset in deep sleep, timer gating, dma pause,
  chip-erase busy tracking and oscillator-stable reporting.
  assumes commands arrive as one-cycle strobes from the debug transport on clk,
  power, cpu, flash and other status inputs are on clk, and the oscillator-stable
  level comes from the analog side and is asynchronous.
*/
// What this block does
// - config byte written and read by commands
// - bit five keeps regulator on in sleep
// - bit five clear resets logic entering sleep
// - bit three disables timers, overriding suspend
// - bit two pauses all dma transfers
// - bit one stops timers on halt, injection
// - single step ticks timers as free-running
// - status byte returned on status read
// - erase busy from erase command to done
// - status bit one shows oscillator stable
`timescale 1ns/1ns
`default_nettype none
module debug_config_status (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // command strobe from the debug transport
   input wire dbg_cfg_pkg::cmd_s cmdIn,
   // answer byte back to the transport
   output var dbg_cfg_pkg::rsp_s rspOut,
   // power manager state
   input wire logic deepSleepTwo,
   input wire logic deepSleepThree,
   // cpu and flash state
   input wire logic cpuHalted,
   input wire logic injectedBusy,
   input wire logic singleStepBusy,
   input wire logic eraseDone,
   // asynchronous oscillator-stable level
   input wire logic oscStableRaw,
   // remaining status bits from other logic
   input wire logic [7:0] otherStatus,
   // controls to the rest of the chip
   output logic regulatorKeepOn,
   output logic debugLogicReset,
   output logic timerRun,
   output logic dmaPause,
   output logic eraseStart
);
   import dbg_cfg_pkg::*;

   logic [7:0] config_ff; // configuration byte
   logic [7:0] nxt_config;
   logic eraseBusy_ff; // chip erase in progress
   logic nxt_eraseBusy;
   logic sleepPrev_ff; // deep sleep level one cycle ago
   logic nxt_sleepPrev;
   rsp_s rsp_ff;
   rsp_s nxt_rsp;
   logic regOn_ff;
   logic nxt_regOn;
   logic ifReset_ff;
   logic nxt_ifReset;
   logic timerRun_ff;
   logic nxt_timerRun;
   logic dmaPause_ff;
   logic nxt_dmaPause;
   logic eraseStart_ff;
   logic nxt_eraseStart;
   logic oscStable; // filtered oscillator level
   logic inSleep; // chip is in either deep sleep mode
   logic sleepEntry; // first cycle of a deep sleep
   logic [7:0] statusByte; // status as seen right now

   // the oscillator level crosses from the analog side
   sync_three oscSync (
      .clk(clk),
      .nrst(nrst),
      .rawIn(oscStableRaw),
      .syncOut(oscStable)
   );

   // current status byte assembly
   always_comb begin
      statusByte = otherStatus & STS_OTHER_MASK;
      statusByte[STS_ERASE_BUSY_BIT] = eraseBusy_ff;
      statusByte[STS_OSC_STABLE_BIT] = oscStable;
   end

   // either deep sleep counts; entry is the first cycle of the combined level
   assign inSleep = deepSleepTwo | deepSleepThree;
   assign sleepEntry = inSleep & ~sleepPrev_ff;

   // next configuration, erase flag and answer
   always_comb begin
      nxt_config = config_ff;
      nxt_eraseBusy = eraseBusy_ff;
      // no answer unless a command was taken this cycle
      nxt_rsp = '0;
      nxt_eraseStart = 1'b0;
      nxt_sleepPrev = inSleep;
      nxt_ifReset = 1'b0;
      // done clears first so that a new erase command in the same cycle wins
      if (eraseDone) begin
         nxt_eraseBusy = 1'b0;
      end
      if (cmdIn.valid) begin
         nxt_rsp.valid = 1'b1;
         unique case (cmdIn.op)
            OP_WR_CONFIG: begin
               // reserved bits are dropped so they can never read back set
               nxt_config = cmdIn.data & CFG_WRITE_MASK;
               nxt_rsp.data = statusByte;
            end
            OP_RD_CONFIG: begin
               nxt_rsp.data = config_ff;
            end
            OP_RD_STATUS: begin
               nxt_rsp.data = statusByte;
            end
            OP_CHIP_ERASE: begin
               // busy rises at once, before the flash controller even starts
               nxt_eraseBusy = 1'b1;
               nxt_eraseStart = 1'b1;
               nxt_rsp.data = statusByte;
            end
         endcase
      end
      // without retention the debug logic loses its state on sleep entry
      if (sleepEntry && !config_ff[CFG_RETAIN_BIT]) begin
         nxt_config = CFG_RESET;
         nxt_ifReset = 1'b1;
         nxt_rsp = '0;
      end
   end

   // next values of the chip-facing controls
   always_comb begin
      // regulator held only when retention is set and a deep sleep is active
      nxt_regOn = nxt_config[CFG_RETAIN_BIT] & inSleep;
      nxt_dmaPause = nxt_config[CFG_DMA_PAUSE_BIT];
      // a clear configuration leaves the timers free-running
      nxt_timerRun = 1'b1;
      if (nxt_config[CFG_TIMERS_OFF_BIT]) begin
         // full disable beats suspend in every case
         nxt_timerRun = 1'b0;
      end else if (nxt_config[CFG_SUSPEND_BIT]) begin
         // a step runs timers exactly for the cycles the instruction takes,
         // so they see the ticks a free run would give
         if (singleStepBusy) begin
            nxt_timerRun = 1'b1;
         end else if (cpuHalted || injectedBusy) begin
            nxt_timerRun = 1'b0;
         end
      end
   end

   // registers only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         config_ff <= CFG_RESET;
         eraseBusy_ff <= 1'b0;
         sleepPrev_ff <= 1'b0;
         rsp_ff <= '0;
         regOn_ff <= 1'b0;
         ifReset_ff <= 1'b0;
         timerRun_ff <= 1'b1;
         // the pause level starts from the configuration reset byte
         dmaPause_ff <= CFG_RESET[CFG_DMA_PAUSE_BIT];
         eraseStart_ff <= 1'b0;
      end else begin
         config_ff <= nxt_config;
         eraseBusy_ff <= nxt_eraseBusy;
         sleepPrev_ff <= nxt_sleepPrev;
         rsp_ff <= nxt_rsp;
         regOn_ff <= nxt_regOn;
         ifReset_ff <= nxt_ifReset;
         timerRun_ff <= nxt_timerRun;
         dmaPause_ff <= nxt_dmaPause;
         eraseStart_ff <= nxt_eraseStart;
      end
   end

   // outputs straight from flip-flops
   assign rspOut = rsp_ff;
   assign regulatorKeepOn = regOn_ff;
   assign debugLogicReset = ifReset_ff;
   assign timerRun = timerRun_ff;
   assign dmaPause = dmaPause_ff;
   assign eraseStart = eraseStart_ff;

   // checks on the behaviour above
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // a config write is read back, masked, on the next config read
   cfg_readback_a: assert property (
      cmdIn.valid && cmdIn.op == OP_WR_CONFIG && !sleepEntry ##1
      cmdIn.valid && cmdIn.op == OP_RD_CONFIG && !sleepEntry
      |-> ##1 rspOut.valid && rspOut.data == ($past(cmdIn.data, 2) & CFG_WRITE_MASK))
      else $error("config readback differs from write");

   // reserved bits never appear in the configuration
   cfg_reserved_a: assert property ((config_ff & ~CFG_WRITE_MASK) == 8'h00)
      else $error("reserved config bit set");

   // regulator follows retention during deep sleep
   reg_retain_a: assert property (
      inSleep && config_ff[CFG_RETAIN_BIT] && !cmdIn.valid |=> regulatorKeepOn)
      else $error("regulator dropped in retained sleep");

   // sleep entry without retention pulses reset and restores defaults
   sleep_reset_a: assert property (
      sleepEntry && !config_ff[CFG_RETAIN_BIT]
      |=> debugLogicReset && config_ff == CFG_RESET ##1 !debugLogicReset)
      else $error("no debug reset on sleep entry");

   // timers off wins over everything
   timers_off_a: assert property (
      config_ff[CFG_TIMERS_OFF_BIT] && !cmdIn.valid && !sleepEntry |=> !timerRun)
      else $error("timers run while disabled");

   // dma pause output tracks bit two
   dma_pause_a: assert property (dmaPause == $past(nxt_config[CFG_DMA_PAUSE_BIT]))
      else $error("dma pause out of step");

   // halted cpu with suspend and no step stops timers
   suspend_halt_a: assert property (
      config_ff == CFG_RESET && !cmdIn.valid && !sleepEntry
      && (cpuHalted || injectedBusy) && !singleStepBusy |=> !timerRun)
      else $error("timers ran while suspended");

   // a step lets timers run unless disabled
   step_ticks_a: assert property (
      singleStepBusy && !config_ff[CFG_TIMERS_OFF_BIT] && !cmdIn.valid && !sleepEntry
      |=> timerRun)
      else $error("timers stalled during step");

   // status read returns the live status byte one cycle later
   status_read_a: assert property (
      cmdIn.valid && cmdIn.op == OP_RD_STATUS && !sleepEntry
      |=> rspOut.valid && rspOut.data == $past(statusByte))
      else $error("status answer wrong");

   // erase busy rises the cycle after the command and holds until done
   erase_busy_a: assert property (
      cmdIn.valid && cmdIn.op == OP_CHIP_ERASE
      |=> eraseBusy_ff && eraseStart
      ##1 (!eraseStart || $past(cmdIn.valid && cmdIn.op == OP_CHIP_ERASE)))
      else $error("erase busy not raised");

   erase_hold_a: assert property (
      eraseBusy_ff && !eraseDone |=> eraseBusy_ff)
      else $error("erase busy dropped early");

   // oscillator bit agrees with the filtered level
   osc_status_a: assert property (statusByte[STS_OSC_STABLE_BIT] == oscStable)
      else $error("oscillator bit wrong");

   // five steady samples of the raw level must have reached the status bit
   osc_rise_a: assert property (
      oscStableRaw [*5] |-> oscStable)
      else $error("oscillator bit late to rise");

   osc_fall_a: assert property (
      !oscStableRaw [*5] |-> !oscStable)
      else $error("oscillator bit late to fall");

   // a config read answers with the byte held when it was taken
   cfg_answer_a: assert property (
      cmdIn.valid && cmdIn.op == OP_RD_CONFIG && !sleepEntry
      |=> rspOut.valid && rspOut.data == $past(config_ff))
      else $error("config answer wrong");

   // no answer appears without a command
   rsp_idle_a: assert property (
      !cmdIn.valid |=> !rspOut.valid)
      else $error("answer without command");

   // busy falls once the flash reports done and no new erase came
   erase_clear_a: assert property (
      eraseDone && !(cmdIn.valid && cmdIn.op == OP_CHIP_ERASE) |=> !eraseBusy_ff)
      else $error("erase busy stuck after done");

   // the start pulse only follows an erase command
   erase_start_a: assert property (
      !(cmdIn.valid && cmdIn.op == OP_CHIP_ERASE) |=> !eraseStart)
      else $error("erase start without command");

   // outside deep sleep the regulator is never held
   reg_off_a: assert property (
      !inSleep |=> !regulatorKeepOn)
      else $error("regulator held outside sleep");

   // the debug reset pulse only follows an unretained sleep entry
   reset_cause_a: assert property (
      debugLogicReset |-> $past(sleepEntry && !config_ff[CFG_RETAIN_BIT]))
      else $error("debug reset without cause");

   // bit two clear lets dma run
   dma_free_a: assert property (
      !config_ff[CFG_DMA_PAUSE_BIT] && !cmdIn.valid && !sleepEntry |=> !dmaPause)
      else $error("dma paused while enabled");

   // neither timer bit set leaves timers running
   timers_free_a: assert property (
      !config_ff[CFG_TIMERS_OFF_BIT] && !config_ff[CFG_SUSPEND_BIT] && !cmdIn.valid
      && !sleepEntry |=> timerRun)
      else $error("timers stopped while free");
endmodule : debug_config_status
`default_nettype wire

// >>> design/sync_three.sv
/*
  three-stage synchroniser for one asynchronous level.
  assumes the level is slow next to clk; a change is taken once stages one and two agree.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_three (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // raw level and its filtered copy
   input wire logic rawIn,
   output logic syncOut
);
   logic [2:0] stage_ff; // stage 0 is read only by stage 1
   logic [2:0] nxt_stage;
   logic out_ff;
   logic nxt_out;

   // shift in and update the output only when the two late stages agree
   always_comb begin
      nxt_stage = {stage_ff[1:0], rawIn};
      nxt_out = out_ff;
      if (stage_ff[1] == stage_ff[2]) begin
         nxt_out = stage_ff[2];
      end
   end

   // registers only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stage_ff <= 3'h0;
         out_ff <= 1'b0;
      end else begin
         stage_ff <= nxt_stage;
         out_ff <= nxt_out;
      end
   end

   assign syncOut = out_ff;
endmodule : sync_three
`default_nettype wire

// >>> verification/debug_config_status_byte_test.sv
/*
  self-checking bench of the debug configuration and status block.
  assumes the host model drives commands; power, cpu and flash levels come from here.
*/
`timescale 1ns/1ns
`default_nettype none
module debug_config_status_byte_test;
   import dbg_cfg_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   cmd_s cmdIn;
   rsp_s rspOut;
   logic deepSleepTwo = 1'b0, deepSleepThree = 1'b0, cpuHalted = 1'b0, injectedBusy = 1'b0;
   logic singleStepBusy = 1'b0, eraseDone = 1'b0, oscStableRaw = 1'b0;
   logic [7:0] otherStatus = 8'h00;
   logic regulatorKeepOn, debugLogicReset, timerRun, dmaPause, eraseStart, ok;
   int nErrors = 0;
   int checked = 0;
   // 20 MHz
   always #25 clk = ~clk;
   debug_config_status DUT (.clk(clk), .nrst(nrst), .cmdIn(cmdIn), .rspOut(rspOut),
      .deepSleepTwo(deepSleepTwo), .deepSleepThree(deepSleepThree), .cpuHalted(cpuHalted),
      .injectedBusy(injectedBusy), .singleStepBusy(singleStepBusy), .eraseDone(eraseDone),
      .oscStableRaw(oscStableRaw), .otherStatus(otherStatus),
      .regulatorKeepOn(regulatorKeepOn), .debugLogicReset(debugLogicReset),
      .timerRun(timerRun), .dmaPause(dmaPause), .eraseStart(eraseStart));
   debug_host_model host (.clk(clk), .cmdOut(cmdIn), .rspIn(rspOut));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // every command must be answered
   task automatic cmd(input cmd_op_e op, input logic [7:0] d, output logic [7:0] v);
      host.issue(op, d, ok, v);
      chk(ok, 8'h01);
   endtask : cmd
   task automatic t_config();
      logic [7:0] v;
      cmd(OP_RD_CONFIG, 8'h00, v);
      chk(v, 8'h26);
      chk(dmaPause, 8'h01);
      chk(timerRun, 8'h01);
      cmd(OP_WR_CONFIG, 8'hFE, v);
      cmd(OP_RD_CONFIG, 8'h00, v);
      chk(v, 8'h2E);
      cmd(OP_WR_CONFIG, 8'h00, v);
      cmd(OP_RD_CONFIG, 8'h00, v);
      chk(v, 8'h00);
      chk(dmaPause, 8'h00);
      $display("config test done");
   endtask : t_config
   task automatic t_status();
      logic [7:0] v;
      cmd(OP_RD_STATUS, 8'h00, v);
      chk(v, 8'h00);
      otherStatus = 8'hFF;
      oscStableRaw = 1'b1;
      repeat (6) @(negedge clk);
      cmd(OP_RD_STATUS, 8'h00, v);
      chk(v, 8'h7F);
      $display("status test done");
   endtask : t_status
   // set halt, inject, step levels and check the timer gate
   task automatic gate(input logic [2:0] his, input logic [7:0] exp);
      {cpuHalted, injectedBusy, singleStepBusy} = his;
      repeat (2) @(negedge clk);
      chk(timerRun, exp);
   endtask : gate
   task automatic t_timers();
      logic [7:0] v;
      cmd(OP_WR_CONFIG, 8'h02, v);
      gate(3'b100, 8'h00);
      gate(3'b010, 8'h00);
      gate(3'b101, 8'h01);
      gate(3'b000, 8'h01);
      cmd(OP_WR_CONFIG, 8'h0A, v);
      gate(3'b001, 8'h00);
      gate(3'b000, 8'h00);
      cmd(OP_WR_CONFIG, 8'h00, v);
      gate(3'b100, 8'h01);
      gate(3'b000, 8'h01);
      $display("timer test done");
   endtask : t_timers
   task automatic t_erase();
      logic [7:0] v;
      int n;
      cmd(OP_CHIP_ERASE, 8'h00, v);
      chk(eraseStart, 8'h01);
      cmd(OP_RD_STATUS, 8'h00, v);
      chk(v, 8'hFF);
      eraseDone = 1'b1;
      @(negedge clk);
      eraseDone = 1'b0;
      n = 0;
      // poll under a bound until busy falls
      do begin
         cmd(OP_RD_STATUS, 8'h00, v);
         n++;
      end while (v[7] !== 1'b0 && n < 20);
      chk(v, 8'h7F);
      $display("erase test done");
   endtask : t_erase
   task automatic t_sleep();
      logic [7:0] v;
      cmd(OP_WR_CONFIG, 8'h26, v);
      deepSleepTwo = 1'b1;
      repeat (2) @(negedge clk);
      chk(regulatorKeepOn, 8'h01);
      chk(debugLogicReset, 8'h00);
      deepSleepTwo = 1'b0;
      repeat (2) @(negedge clk);
      cmd(OP_WR_CONFIG, 8'h06, v);
      deepSleepThree = 1'b1;
      @(negedge clk);
      chk(debugLogicReset, 8'h01);
      @(negedge clk);
      // the restored byte has retention set, so the regulator is held
      chk(regulatorKeepOn, 8'h01);
      deepSleepThree = 1'b0;
      cmd(OP_RD_CONFIG, 8'h00, v);
      chk(v, 8'h26);
      chk(regulatorKeepOn, 8'h00);
      $display("sleep test done");
   endtask : t_sleep
   // a reset in mid-run brings the byte and the controls back to reset levels
   task automatic t_reset();
      logic [7:0] v;
      cmd(OP_WR_CONFIG, 8'h08, v);
      chk(dmaPause, 8'h00);
      chk(timerRun, 8'h00);
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      chk(timerRun, 8'h01);
      chk(dmaPause, 8'h01);
      nrst = 1'b1;
      cmd(OP_RD_CONFIG, 8'h00, v);
      chk(v, 8'h26);
      $display("reset test done");
   endtask : t_reset
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   // main sequence after six cycles of reset
   initial begin
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      t_config();
      t_status();
      t_timers();
      t_erase();
      t_sleep();
      t_reset();
      close_out();
   end
   // watchdog: the tests need well under a thousand cycles
   initial begin
      #200000;
      nErrors++;
      close_out();
   end
endmodule : debug_config_status_byte_test
`default_nettype wire

// >>> verification/debug_host_model.sv
/*
  debug host model: sends one command strobe at a time and collects the answer byte.
  assumes the block takes a command on the rising edge of clk and answers one cycle later.
*/
`timescale 1ns/1ns
`default_nettype none
module debug_host_model
   import dbg_cfg_pkg::*;
(
   // clock
   input wire logic clk,
   // command out, answer in
   output var dbg_cfg_pkg::cmd_s cmdOut,
   input wire dbg_cfg_pkg::rsp_s rspIn
);
   // idle until the first transfer
   initial cmdOut = '0;
   // a config write always leaves here with bit zero cleared; the dma pause bit two passes as given
   // drive after a falling edge, hold across the taking edge, then read the answer
   task automatic issue(input cmd_op_e op, input logic [7:0] d, output logic ok,
                        output logic [7:0] r);
      @(negedge clk);
      cmdOut = {1'b1, op, (op == OP_WR_CONFIG) ? (d & 8'hFE) : d};
      @(negedge clk);
      // released lines show the inverse so a stale value cannot pass
      cmdOut = {1'b0, ~op, ~cmdOut.data};
      ok = rspIn.valid;
      r = rspIn.data;
   endtask : issue
endmodule : debug_host_model
`default_nettype wire
